/* verilog/hmc_mode_cfg.sv */
`timescale 1ns/1ps
// Overview of operation
// - Write lands only directly after unlocking read
// - Intervening access redirects write to count high
// - Page 0 read at offset returns register
// - Two media bits select one of four
// - Twisted pair pins or attachment port routing
// - Coax output low thick, high thin
// - Writing link bit one disables link test
// - Link bit reads status per mode rules
// - Link bit read equals link LED
// - Timing bit picks strobe or decode indication
// - Unhonoured wait states set bus error
// - Write one clears bus error, zero ignored
// - Boot ROM writes blocked while enable low
// - Writing load bit starts EEPROM load
module hmc_mode_cfg (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Register access port
  input  wire hmc_pkg::hmc_req_s req,
  output logic           [7:0]  rdata_reg,
  output logic                  rbc_hi_wr_reg,
  output logic           [7:0]  rbc_hi_data_reg,
  // Physical layer control and status
  input  wire logic             link_pulse_ok,
  output hmc_pkg::hmc_phy_s     phy_reg,
  output logic                  coax_type_reg,
  output logic                  link_led_reg,
  output logic                  link_test_disable_reg,
  // Host bus pins and timing
  input  wire logic             io_read_strobe_n,
  input  wire logic             io_write_strobe_n,
  input  wire logic             addr_decode_hit,
  input  wire logic             wait_insert,
  output logic                  wide_io_ind_reg,
  // Boot ROM and EEPROM
  input  wire logic             rom_wr_req,
  output logic                  boot_rom_wr_reg,
  output logic                  eeprom_load_start_reg
);

  // Stored fields of the register
  hmc_pkg::hmc_media_e media_reg, media_next;
  hmc_pkg::hmc_lock_e  lock_reg, lock_next;     // Unlock flag
  logic wio_reg, wio_next;                      // Wide I/O timing select
  logic rsv_reg, rsv_next;                      // Reserved bit, stored as written
  logic berr_reg, berr_next;                    // Bus error flag
  logic boot_rom_write_enable_reg, boot_rom_write_enable_next;                    // Boot ROM write enable
  logic [7:0] rdata_next;
  logic [7:0] rbc_data_next;
  logic rbc_wr_next, eeld_next, led_next, ltd_next, coax_next, wio_ind_next, rom_next;
  hmc_pkg::hmc_phy_s phy_next;

  // Decoded strobes and events
  logic [1:0] strobe_lvl;                       // Filtered active-low strobes
  logic       strobe_act, strobe_act_reg;
  logic       berr_event, hit_rd, hit_wr, cfg_wr;
  logic [7:0] image;

  // Both read and write use the same hidden address decode
  function automatic logic hit_cfgb(input hmc_pkg::hmc_req_s r);
    return (r.page == hmc_pkg::HMC_PAGE0) && (r.ofs == hmc_pkg::HMC_CFGB_OFS);
  endfunction : hit_cfgb

  // True for the two attachment unit port selections
  function automatic logic is_aui(input hmc_pkg::hmc_media_e m);
    return (m == hmc_pkg::HMC_THIN) || (m == hmc_pkg::HMC_THICK);
  endfunction : is_aui

  // Strobe pins come from the host bus, outside this clock domain
  hmc_pin_sync u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin_in    ({io_write_strobe_n, io_read_strobe_n}),
    .level_reg (strobe_lvl)
  );

  assign strobe_act = ~(&strobe_lvl);
  // Host ended its cycle while we still held wait states
  assign berr_event = strobe_act_reg && !strobe_act && wait_insert;
  assign hit_rd     = req.rd && hit_cfgb(req);
  assign hit_wr     = req.wr && hit_cfgb(req);
  assign cfg_wr     = hit_wr && (lock_reg == hmc_pkg::HMC_UNLOCKED);

  // Read image; load bit self-clears so it always reads zero
  always_comb begin
    image = hmc_pkg::HMC_BYTE_RESET;
    image[hmc_pkg::HMC_MEDIA_MSB:hmc_pkg::HMC_MEDIA_LSB] = media_reg;
    image[hmc_pkg::HMC_LINK_BIT] = link_led_reg;
    image[hmc_pkg::HMC_WIO_BIT]  = wio_reg;
    image[hmc_pkg::HMC_RSV_BIT]  = rsv_reg;
    image[hmc_pkg::HMC_BERR_BIT] = berr_reg;
    image[hmc_pkg::HMC_BOOT_ROM_WRITE_ENABLE_BIT] = boot_rom_write_enable_reg;
  end

  // Next state of the register fields and access results
  always_comb begin
    lock_next     = lock_reg;
    media_next    = media_reg;
    wio_next      = wio_reg;
    rsv_next      = rsv_reg;
    boot_rom_write_enable_next     = boot_rom_write_enable_reg;
    ltd_next      = link_test_disable_reg;
    berr_next     = berr_reg;
    rdata_next    = rdata_reg;
    rbc_wr_next   = 1'b0;
    rbc_data_next = rbc_hi_data_reg;
    eeld_next     = 1'b0;
    // Any access relocks except the unlocking read itself
    if (req.rd || req.wr) begin
      lock_next = hit_rd ? hmc_pkg::HMC_UNLOCKED : hmc_pkg::HMC_LOCKED;
    end
    if (hit_rd) begin
      rdata_next = image;
    end
    if (cfg_wr) begin
      media_next = hmc_pkg::hmc_media_e'(
        req.wdata[hmc_pkg::HMC_MEDIA_MSB:hmc_pkg::HMC_MEDIA_LSB]);
      ltd_next   = req.wdata[hmc_pkg::HMC_LINK_BIT];
      wio_next   = req.wdata[hmc_pkg::HMC_WIO_BIT];
      rsv_next   = req.wdata[hmc_pkg::HMC_RSV_BIT];
      boot_rom_write_enable_next  = req.wdata[hmc_pkg::HMC_BOOT_ROM_WRITE_ENABLE_BIT];
      eeld_next  = req.wdata[hmc_pkg::HMC_EELD_BIT];
      if (req.wdata[hmc_pkg::HMC_BERR_BIT]) begin
        berr_next = 1'b0;
      end
    end else if (hit_wr) begin
      // Locked write falls through to the remote count high byte
      rbc_wr_next   = 1'b1;
      rbc_data_next = req.wdata;
    end
    // Set wins over a clear in the same cycle
    if (berr_event) begin
      berr_next = 1'b1;
    end
  end

  // Next values of the pin-facing outputs
  always_comb begin
    phy_next.tp_route        = !is_aui(media_reg);
    phy_next.aui_route       = is_aui(media_reg);
    phy_next.reduced_squelch = (media_reg == hmc_pkg::HMC_TP_LOW);
    // Thick drives low; twisted pair leaves the line high
    coax_next = (media_reg != hmc_pkg::HMC_THICK);
    if (is_aui(media_reg)) begin
      led_next = 1'b0;
    end else if (link_test_disable_reg) begin
      led_next = 1'b1;
    end else begin
      led_next = link_pulse_ok;
    end
    // Either wait for a strobe or answer on decode alone
    wio_ind_next = addr_decode_hit && (!wio_reg || strobe_act);
    rom_next     = rom_wr_req && boot_rom_write_enable_reg;
  end

  // All state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_reg              <= hmc_pkg::HMC_LOCKED;
      media_reg             <= hmc_pkg::hmc_media_e'(hmc_pkg::HMC_MEDIA_RESET);
      wio_reg               <= hmc_pkg::HMC_BIT_RESET;
      rsv_reg               <= hmc_pkg::HMC_BIT_RESET;
      berr_reg              <= hmc_pkg::HMC_BIT_RESET;
      boot_rom_write_enable_reg              <= hmc_pkg::HMC_BIT_RESET;
      link_test_disable_reg <= hmc_pkg::HMC_BIT_RESET;
      rdata_reg             <= hmc_pkg::HMC_BYTE_RESET;
      rbc_hi_wr_reg         <= 1'b0;
      rbc_hi_data_reg       <= hmc_pkg::HMC_BYTE_RESET;
      eeprom_load_start_reg <= 1'b0;
      phy_reg               <= '0;
      coax_type_reg         <= 1'b0;
      link_led_reg          <= 1'b0;
      wide_io_ind_reg       <= 1'b0;
      boot_rom_wr_reg       <= 1'b0;
      strobe_act_reg        <= 1'b0;
    end else begin
      lock_reg              <= lock_next;
      media_reg             <= media_next;
      wio_reg               <= wio_next;
      rsv_reg               <= rsv_next;
      berr_reg              <= berr_next;
      boot_rom_write_enable_reg              <= boot_rom_write_enable_next;
      link_test_disable_reg <= ltd_next;
      rdata_reg             <= rdata_next;
      rbc_hi_wr_reg         <= rbc_wr_next;
      rbc_hi_data_reg       <= rbc_data_next;
      eeprom_load_start_reg <= eeld_next;
      phy_reg               <= phy_next;
      coax_type_reg         <= coax_next;
      link_led_reg          <= led_next;
      wide_io_ind_reg       <= wio_ind_next;
      boot_rom_wr_reg       <= rom_next;
      strobe_act_reg        <= strobe_act;
    end
  end

  a_unlocked_write_lands: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_wr |=> (media_reg == $past(req.wdata[hmc_pkg::HMC_MEDIA_MSB:hmc_pkg::HMC_MEDIA_LSB]))
      && !rbc_hi_wr_reg)
    else $error("unlocked write did not update the register");

  a_locked_write_redirect: assert property (@(posedge ref_clk) disable iff (rst)
    (hit_wr && lock_reg == hmc_pkg::HMC_LOCKED)
      |=> rbc_hi_wr_reg && (rbc_hi_data_reg == $past(req.wdata)) && $stable(media_reg))
    else $error("locked write not redirected");

  a_lock_flag_clear: assert property (@(posedge ref_clk) disable iff (rst)
    ((req.rd || req.wr) && !hit_rd) |=> lock_reg == hmc_pkg::HMC_LOCKED)
    else $error("unlock flag survived another access");

  a_read_image_link: assert property (@(posedge ref_clk) disable iff (rst)
    hit_rd |=> (rdata_reg == $past(image))
      && (rdata_reg[hmc_pkg::HMC_LINK_BIT] == $past(link_led_reg)))
    else $error("hidden read returned wrong value");

  a_coax_thick_low: assert property (@(posedge ref_clk) disable iff (rst)
    (media_reg == hmc_pkg::HMC_THICK) |=> !coax_type_reg && phy_reg.aui_route)
    else $error("thick media did not drive coax output low");

  a_link_disabled_good: assert property (@(posedge ref_clk) disable iff (rst)
    (link_test_disable_reg && !is_aui(media_reg)) |=> link_led_reg)
    else $error("disabled link test did not read good");

  a_berr_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    berr_event |=> berr_reg)
    else $error("bus error not flagged");

  a_berr_write_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_wr && req.wdata[hmc_pkg::HMC_BERR_BIT] && !berr_event) |=> !berr_reg)
    else $error("bus error not cleared by writing one");

  a_rom_write_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !boot_rom_write_enable_reg |=> !boot_rom_wr_reg)
    else $error("boot ROM write while disabled");

  a_eeprom_load_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_wr && req.wdata[hmc_pkg::HMC_EELD_BIT])
      |=> eeprom_load_start_reg ##1 !eeprom_load_start_reg)
    else $error("EEPROM load start not a single pulse");

  a_wide_io_decode: assert property (@(posedge ref_clk) disable iff (rst)
    (!wio_reg && addr_decode_hit) |=> wide_io_ind_reg)
    else $error("indicator not asserted on decode");

endmodule : hmc_mode_cfg

/* verilog/hmc_pkg.sv */
package hmc_pkg;

  // Page and offset at which the hidden register sits
  localparam logic [1:0] HMC_PAGE0    = 2'h0;
  localparam logic [3:0] HMC_CFGB_OFS = 4'hb;

  // Field positions inside the media and bus option register
  localparam int HMC_MEDIA_LSB = 0;
  localparam int HMC_MEDIA_MSB = 1;
  localparam int HMC_LINK_BIT  = 2;
  localparam int HMC_WIO_BIT   = 3;
  localparam int HMC_RSV_BIT   = 4;
  localparam int HMC_BERR_BIT  = 5;
  localparam int HMC_BOOT_ROM_WRITE_ENABLE_BIT  = 6;
  localparam int HMC_EELD_BIT  = 7;

  // Reset values of the stored fields
  localparam logic [1:0] HMC_MEDIA_RESET = 2'h0;
  localparam logic       HMC_BIT_RESET   = 1'h0;
  localparam logic [7:0] HMC_BYTE_RESET  = 8'h00;

  // Media selection codes
  typedef enum logic [1:0] {
    HMC_TP_STD = 2'b00,
    HMC_THIN   = 2'b01,
    HMC_THICK  = 2'b10,
    HMC_TP_LOW = 2'b11
  } hmc_media_e;

  // Unlock state of the hidden register
  typedef enum logic {
    HMC_LOCKED   = 1'b0,
    HMC_UNLOCKED = 1'b1
  } hmc_lock_e;

  // One register access from the host bus front end
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] page;
    logic [3:0] ofs;
    logic [7:0] wdata;
  } hmc_req_s;

  // Physical layer steering
  typedef struct packed {
    logic tp_route;
    logic aui_route;
    logic reduced_squelch;
  } hmc_phy_s;

endpackage : hmc_pkg

/* verilog/hmc_pin_sync.sv */
`timescale 1ns/1ps
// Three-stage synchroniser for the two host strobe pins; the output only
// follows once the second and third stages agree, which filters one-cycle
// glitches at the cost of one more cycle of latency.
module hmc_pin_sync (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Raw pins and filtered levels
  input  wire logic [1:0] pin_in,
  output logic      [1:0] level_reg
);

  // Idle level of both active-low strobes, so reset never fakes an edge
  localparam logic [1:0] IDLE_LVL = 2'h3;

  logic [1:0] st1_reg;  // First stage, read only by the second
  logic [1:0] st2_reg;  // Second stage
  logic [1:0] st3_reg;  // Third stage
  logic [1:0] level_next;

  // Accept a change once stages two and three agree
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < 2; i++) begin
      if (st2_reg[i] == st3_reg[i]) begin
        level_next[i] = st3_reg[i];
      end
    end
  end

  // Stage registers; strobes are active low so idle is all ones
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st1_reg   <= IDLE_LVL;
      st2_reg   <= IDLE_LVL;
      st3_reg   <= IDLE_LVL;
      level_reg <= IDLE_LVL;
    end else begin
      st1_reg   <= pin_in;
      st2_reg   <= st1_reg;
      st3_reg   <= st2_reg;
      level_reg <= level_next;
    end
  end

endmodule : hmc_pin_sync

/* tb/hmc_host_model.sv */
`timescale 1ns/1ps
// Host bus model: strobe pins, address decode and the wait request line
module hmc_host_model (
  // Clock
  input  wire logic ref_clk,
  // Host side lines toward the block
  output logic      io_read_strobe_n,
  output logic      io_write_strobe_n,
  output logic      addr_decode_hit,
  output logic      wait_insert
);
  // Strobes idle high, as on a pulled-up bus
  initial begin
    io_read_strobe_n  = 1'b1;
    io_write_strobe_n = 1'b1;
    addr_decode_hit   = 1'b0;
    wait_insert       = 1'b0;
  end

  // Open a cycle; strb_n is {write, read}, 2'b11 gives decode alone
  task automatic open_cycle(input logic [1:0] strb_n, input logic hold);
    @(posedge ref_clk);
    addr_decode_hit <= 1'b1;
    wait_insert     <= hold;
    {io_write_strobe_n, io_read_strobe_n} <= strb_n;
  endtask : open_cycle

  // End the cycle at once, even while waits are still asked for
  task automatic close_cycle;
    @(posedge ref_clk);
    {io_write_strobe_n, io_read_strobe_n} <= 2'b11;
    addr_decode_hit <= 1'b0;
    // Wait line outlives the strobe so the filtered edge sees it
    repeat (8) @(posedge ref_clk);
    wait_insert <= 1'b0;
  endtask : close_cycle
endmodule : hmc_host_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the hidden media and bus option register
module tb_top;
  localparam logic [3:0] OFS = hmc_pkg::HMC_CFGB_OFS;
  logic ref_clk = 1'b0;
  logic rst, link_pulse_ok, rom_wr_req, rd_seen = 1'b0;
  hmc_pkg::hmc_req_s req;
  hmc_pkg::hmc_phy_s phy_reg;
  logic [7:0] rdata_reg, rbc_hi_data_reg;
  logic rbc_hi_wr_reg, coax_type_reg, link_led_reg, link_test_disable_reg;
  logic wide_io_ind_reg, boot_rom_wr_reg, eeprom_load_start_reg;
  logic io_read_strobe_n, io_write_strobe_n, addr_decode_hit, wait_insert;
  // Expected read images and redirected write data, oldest first
  logic [7:0] rd_q[$];
  logic [7:0] rbc_q[$];
  // Bench copy of the register fields
  logic [1:0] media;
  logic dis, wio, berr, boot_rom_write_enable;
  int n_fail = 0, checks = 0, ee_exp = 0, ee_seen = 0;
  logic [31:0] r;

  always #2.5 ref_clk = ~ref_clk;

  hmc_mode_cfg dut (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata_reg(rdata_reg),
    .rbc_hi_wr_reg(rbc_hi_wr_reg), .rbc_hi_data_reg(rbc_hi_data_reg),
    .link_pulse_ok(link_pulse_ok), .phy_reg(phy_reg), .coax_type_reg(coax_type_reg),
    .link_led_reg(link_led_reg), .link_test_disable_reg(link_test_disable_reg),
    .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
    .addr_decode_hit(addr_decode_hit), .wait_insert(wait_insert),
    .wide_io_ind_reg(wide_io_ind_reg), .rom_wr_req(rom_wr_req),
    .boot_rom_wr_reg(boot_rom_wr_reg), .eeprom_load_start_reg(eeprom_load_start_reg));

  hmc_host_model host (.ref_clk(ref_clk), .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n), .addr_decode_hit(addr_decode_hit),
    .wait_insert(wait_insert));

  // Compare one value and count it
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Expected read image; link bit reads 0 on the attachment port
  function automatic logic [7:0] img();
    logic lk;
    lk = (media == hmc_pkg::HMC_THIN || media == hmc_pkg::HMC_THICK) ? 1'b0 :
         (dis ? 1'b1 : link_pulse_ok);
    return {1'b0, boot_rom_write_enable, berr, 1'b0, wio, lk, media};
  endfunction : img

  // One register access on page 0; a hidden read leaves a note
  task automatic acc(input logic rd, input logic [3:0] ofs, input logic [7:0] d);
    req <= '{rd: rd, wr: ~rd, page: hmc_pkg::HMC_PAGE0, ofs: ofs, wdata: d};
    if (rd && ofs == OFS) rd_q.push_back(img());
    if (!rd && ofs == OFS) rbc_q.push_back(d);
    @(posedge ref_clk);
  endtask : acc

  // Bus goes quiet for n cycles
  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge ref_clk);
  endtask : idle

  // Unlocking read then write; bench copy taken from the written byte, never read back
  task automatic wrh(input logic [7:0] d);
    acc(1'b1, OFS, 8'h00);
    acc(1'b0, OFS, d);
    void'(rbc_q.pop_back());
    media = d[1:0];
    dis   = d[2];
    wio   = d[3];
    boot_rom_write_enable  = d[6];
    if (d[5]) berr = 1'b0;
    if (d[7]) ee_exp++;
    idle(4);
  endtask : wrh

  // Watches outputs and takes the oldest note when a result shows
  always @(posedge ref_clk) begin
    if (rd_seen) chk("read data", rd_q.pop_front(), rdata_reg);
    if (rbc_hi_wr_reg) chk("count high data", rbc_q.pop_front(), rbc_hi_data_reg);
    if (eeprom_load_start_reg) ee_seen++;
    rd_seen <= req.rd && req.page == hmc_pkg::HMC_PAGE0 && req.ofs == OFS;
  end

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hac68));
    rst <= 1'b1;
    req <= '0;
    link_pulse_ok <= 1'b1;
    rom_wr_req <= 1'b1;
    {media, dis, wio, berr, boot_rom_write_enable} = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    idle(3);
    acc(1'b1, OFS, 8'h00);
    idle(2);
    // Every media code, random link, timing and boot write bits
    for (int m = 0; m < 4; m++) begin
      r = $urandom;
      link_pulse_ok <= r[0];
      rom_wr_req <= r[1];
      wrh({1'b0, r[6], 1'b0, 1'b0, r[3], r[2], m[1:0]});
      chk("phy", {5'h0, media == 2'h0 || media == 2'h3, media == 2'h1 || media == 2'h2,
          media == 2'h3}, {5'h0, phy_reg});
      chk("coax", {7'h0, media != hmc_pkg::HMC_THICK}, {7'h0, coax_type_reg});
      chk("led", (img() >> 2) & 8'h01, {7'h0, link_led_reg});
      chk("link off", {7'h0, dis}, {7'h0, link_test_disable_reg});
      chk("rom wr", {7'h0, boot_rom_write_enable & rom_wr_req}, {7'h0, boot_rom_wr_reg});
      acc(1'b1, OFS, 8'h00);
      idle(2);
    end
    // Intervening access and a write with no read both go to count high
    acc(1'b1, OFS, 8'h00);
    acc(1'b1, 4'h3, 8'h00);
    acc(1'b0, OFS, 8'($urandom));
    idle(3);
    acc(1'b0, OFS, 8'h5a);
    acc(1'b1, OFS, 8'h00);
    idle(3);
    // Indication on decode alone, then only with a strobe
    wrh(8'h00);
    host.open_cycle(2'b11, 1'b0);
    repeat (8) @(posedge ref_clk);
    chk("wide io", 8'h01, {7'h0, wide_io_ind_reg});
    host.close_cycle();
    wrh(8'h08);
    host.open_cycle(2'b11, 1'b0);
    repeat (8) @(posedge ref_clk);
    chk("wide io", 8'h00, {7'h0, wide_io_ind_reg});
    host.close_cycle();
    host.open_cycle(2'b10, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk("wide io", 8'h01, {7'h0, wide_io_ind_reg});
    // Host ends the cycle while waits are held: bus error
    host.close_cycle();
    berr = 1'b1;
    acc(1'b1, OFS, 8'h00);
    wrh(8'h08);
    wrh(8'h28);
    wrh(8'h88);
    acc(1'b1, OFS, 8'h00);
    idle(4);
    chk("load pulses", ee_exp[7:0], ee_seen[7:0]);
    // Every noted read and redirect must have shown up by now
    chk("notes left", 8'h00, 8'(rd_q.size() + rbc_q.size()));
    wrap_up();
  end
endmodule : tb_top
